// ===== src/bitr_timer.sv
// Basic 8-bit interval timer with crystal interval mode and green wake
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R1) 8-bit up counter, one step per tick
// (R2) Counter holds while run enable is 0
// (R3) Wrap FF to 00 sets sticky overflow flag
// (R4) No reload; counting continues from zero
// (R5) Enabled overflow raises interrupt, vector 8
// (R6) Service routine clears the overflow flag
// (R7) Counts in every mode; green overflow wakes
// (R8) Select codes 000..111 divide 128..1
// (R9) Clock mode picks high or low oscillator
// (R10) Mode bit 0 selects external 32 kHz crystal
// (R11) Crystal mode: 32768/64 clock, 0.5 s
// (R12) Crystal mode only with crystal option strap
// (R13) Prescale select ignored in crystal mode
// (R14) Software leaves count alone in crystal mode
// (R15) Software configures before setting run enable
// (R16) Mode: run bit7, select 6:4, crystal bit0
// (R17) Software loads and reloads the start count
// (R18) Count write beats increment in same cycle
module bitr_timer (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // Oscillator and crystal inputs
   input  wire logic        hosc_in,
   input  wire logic        losc_in,
   input  wire logic        xtal_in,
   // System state and option
   input  wire logic        option_strap,
   input  wire logic        green_mode,
   // Interrupt and wake
   output logic             irq,
   output logic      [7:0]  irq_vector,
   output logic             wake_req
);

   bitr_tick_if tif ();

   logic        run_enable;
   logic [2:0]  prescale_select;
   logic        rtc_source_select;
   logic [7:0]  count;
   logic        overflow_flag;
   logic        overflow_irq_enable;
   logic        system_clock_mode;
   logic        crystal_option;
   logic        option_taken;
   logic        rtc_active;
   logic        overflow;
   logic        wr_mode;
   logic        wr_count;
   logic        wr_status;
   logic        wr_mask;
   logic        wr_sysctl;
   logic        flag_clear;
   logic        next_flag;
   logic [7:0]  next_rdata;

   // Prescaler with oscillator synchronisers
   bitr_prescaler u_psc (
      .core_clk (core_clk),
      .nrst     (nrst),
      .hosc_in  (hosc_in),
      .losc_in  (losc_in),
      .xtal_in  (xtal_in),
      .tif      (tif)
   );

   // Register write decode
   assign wr_mode   = reg_wr && (reg_addr == bitr_pkg::MODE_ADDR);
   assign wr_count  = reg_wr && (reg_addr == bitr_pkg::COUNT_ADDR);
   assign wr_status = reg_wr && (reg_addr == bitr_pkg::STATUS_ADDR);
   assign wr_mask   = reg_wr && (reg_addr == bitr_pkg::MASK_ADDR);
   assign wr_sysctl = reg_wr && (reg_addr == bitr_pkg::SYSCTL_ADDR);

   // Crystal option strap caught once after reset release
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         crystal_option <= 1'b0;
         option_taken   <= 1'b0;
      end else if (!option_taken) begin
         crystal_option <= option_strap;
         option_taken   <= 1'b1;
      end
   end

   // Mode register fields
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         run_enable        <= bitr_pkg::MODE_RESET[bitr_pkg::RUN_BIT]; // [R16]
         prescale_select   <= bitr_pkg::MODE_RESET[bitr_pkg::PSC_HI:bitr_pkg::PSC_LO];
         rtc_source_select <= bitr_pkg::MODE_RESET[bitr_pkg::RTC_BIT];
      end else if (wr_mode) begin
         run_enable        <= reg_wdata[bitr_pkg::RUN_BIT]; // [R16]
         prescale_select   <= reg_wdata[bitr_pkg::PSC_HI:bitr_pkg::PSC_LO]; // [R16]
         rtc_source_select <= reg_wdata[bitr_pkg::RTC_BIT]; // [R16]
      end
   end

   // Interrupt mask and system clock mode
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         overflow_irq_enable <= 1'b0;
         system_clock_mode   <= 1'b0;
      end else begin
         if (wr_mask) begin
            overflow_irq_enable <= reg_wdata[bitr_pkg::OVF_BIT];
         end
         if (wr_sysctl) begin
            system_clock_mode <= reg_wdata[bitr_pkg::SYSTEM_CLOCK_MODE_BIT];
         end
      end
   end

   // Crystal path only exists with the matching option
   assign rtc_active = rtc_source_select & crystal_option; // [R12]

   // Prescaler control
   assign tif.run     = run_enable; // [R2]
   assign tif.psc_sel = prescale_select;

   // Source choice: crystal, else oscillator by clock mode
   always_comb begin
      if (rtc_active) begin
         tif.src = bitr_pkg::SRC_RTC; // [R10] [R13]
      end else if (system_clock_mode) begin
         tif.src = bitr_pkg::SRC_LOSC; // [R9]
      end else begin
         tif.src = bitr_pkg::SRC_HOSC; // [R9]
      end
   end

   // Wrap from full scale
   assign overflow = tif.tick && (count == bitr_pkg::CNT_MAX) && !wr_count; // [R3]

   // Counter; a software write wins over a tick
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         count <= bitr_pkg::COUNT_RESET;
      end else if (wr_count) begin
         count <= reg_wdata; // [R18]
      end else if (tif.tick) begin
         count <= count + bitr_pkg::CNT_ONE; // [R1] [R4] [R11]
      end
   end

   // Sticky flag; a new overflow wins over a clear
   assign flag_clear = wr_status && reg_wdata[bitr_pkg::OVF_BIT];
   assign next_flag  = overflow | (overflow_flag & ~flag_clear); // [R3] [R6]

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         overflow_flag <= 1'b0;
      end else begin
         overflow_flag <= next_flag; // [R3]
      end
   end

   // Level interrupt and fixed vector
   assign irq = overflow_flag & overflow_irq_enable; // [R5]

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         irq_vector <= bitr_pkg::VECTOR_ADDR;
      end else begin
         irq_vector <= bitr_pkg::VECTOR_ADDR; // [R5]
      end
   end

   // Wake pulse on overflow during green mode
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         wake_req <= 1'b0;
      end else begin
         wake_req <= overflow & green_mode; // [R7]
      end
   end

   // Read multiplexer; unmapped addresses read zero
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         bitr_pkg::MODE_ADDR: begin
            next_rdata[bitr_pkg::RUN_BIT]                  = run_enable; // [R16]
            next_rdata[bitr_pkg::PSC_HI:bitr_pkg::PSC_LO]  = prescale_select;
            next_rdata[bitr_pkg::RTC_BIT]                  = rtc_source_select;
         end
         bitr_pkg::COUNT_ADDR: next_rdata = count;
         bitr_pkg::STATUS_ADDR: next_rdata[bitr_pkg::OVF_BIT] = overflow_flag;
         bitr_pkg::MASK_ADDR: next_rdata[bitr_pkg::OVF_BIT] = overflow_irq_enable;
         bitr_pkg::SYSCTL_ADDR: begin
            next_rdata[bitr_pkg::SYSTEM_CLOCK_MODE_BIT] = system_clock_mode;
            next_rdata[bitr_pkg::OPT_BIT]   = crystal_option;
         end
         default: next_rdata = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence s_wrap;
      tif.tick && count == bitr_pkg::CNT_MAX && !wr_count;
   endsequence

   sequence s_flag_up;
      overflow_flag;
   endsequence

   sequence s_step;
      tif.tick && !wr_count;
   endsequence

   property p_wrap_to_zero;
      s_wrap |=> count == 8'h00 ##0 s_flag_up;
   endproperty

   property p_irq_follows;
      s_wrap ##0 overflow_irq_enable && !wr_mask
         |=> irq && irq_vector == 8'h08;
   endproperty

   a_count_step: assert property (s_step // [R1]
      |=> count == $past(count) + 8'h01)
      else $error("count did not step by one");

   a_count_hold: assert property (!run_enable && !wr_count // [R2]
      |=> $stable(count))
      else $error("count moved while stopped");

   a_wrap_flag: assert property (p_wrap_to_zero) // [R3] [R4]
      else $error("wrap did not clear count or set flag");

   a_flag_sticky: assert property (overflow_flag && !flag_clear // [R3]
      |=> overflow_flag [*1])
      else $error("flag dropped without clear");

   a_set_beats_clear: assert property (overflow && flag_clear // [R3]
      |=> overflow_flag)
      else $error("clear hid an overflow");

   a_irq_vector: assert property (p_irq_follows) // [R5]
      else $error("overflow gave no interrupt");

   a_irq_masked: assert property (!overflow_irq_enable |-> !irq) // [R5]
      else $error("masked interrupt raised");

   a_green_wake: assert property (s_wrap ##0 green_mode // [R7]
      |=> wake_req ##1 !wake_req)
      else $error("green overflow gave no single wake pulse");

   a_no_wake_awake: assert property (!green_mode && !$past(green_mode) |-> !wake_req) // [R7]
      else $error("wake outside green mode");

   a_write_wins: assert property (wr_count // [R18]
      |=> count == $past(reg_wdata))
      else $error("count write lost");

   a_crystal_gate: assert property (rtc_source_select && !crystal_option // [R12]
      |-> tif.src != bitr_pkg::SRC_RTC)
      else $error("crystal used without option");

   a_mode_read: assert property (reg_rd && reg_addr == bitr_pkg::MODE_ADDR && !reg_wr // [R16]
      |=> reg_rdata == {$past(run_enable), $past(prescale_select), 3'h0,
                        $past(rtc_source_select)})
      else $error("mode register read wrong");

   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) // [R16]
      else $error("read data outside its cycle");

   // Source choice follows crystal select, strap and clock mode
   a_src_high: assert property (!rtc_active && !system_clock_mode // [R9]
      |-> tif.src == bitr_pkg::SRC_HOSC)
      else $error("high oscillator not chosen");

   a_src_low: assert property (!rtc_active && system_clock_mode // [R9]
      |-> tif.src == bitr_pkg::SRC_LOSC)
      else $error("low oscillator not chosen");

   a_src_crystal: assert property (rtc_source_select && crystal_option // [R10]
      |-> tif.src == bitr_pkg::SRC_RTC)
      else $error("crystal not chosen");

   a_tick_stopped: assert property (!run_enable |-> !tif.tick) // [R2]
      else $error("tick while stopped");

   // Flag and wake only come from a wrap
   a_flag_from_wrap: assert property ($rose(overflow_flag) |-> $past(overflow)) // [R3]
      else $error("flag set without a wrap");

   a_clear_works: assert property (overflow_flag && flag_clear && !overflow // [R3]
      |=> !overflow_flag)
      else $error("flag clear ignored");

   a_wake_from_wrap: assert property (wake_req // [R7]
      |-> $past(overflow) && $past(green_mode))
      else $error("wake without green overflow");

   // Strap is caught once and then held
   a_strap_held: assert property (option_taken |=> $stable(crystal_option)) // [R12]
      else $error("crystal option changed after capture");

   // Read data of count, status, mask and system control
   sequence s_read_count;
      reg_rd && !reg_wr && reg_addr == bitr_pkg::COUNT_ADDR;
   endsequence

   a_count_read: assert property (s_read_count |=> reg_rdata == $past(count)) // [R1]
      else $error("count register read wrong");

   a_status_read: assert property (reg_rd && reg_addr == bitr_pkg::STATUS_ADDR // [R3]
      |=> reg_rdata == {7'h00, $past(overflow_flag)})
      else $error("status register read wrong");

   a_mask_read: assert property (reg_rd && reg_addr == bitr_pkg::MASK_ADDR // [R5]
      |=> reg_rdata == {7'h00, $past(overflow_irq_enable)})
      else $error("mask register read wrong");

   a_sysctl_read: assert property (reg_rd && reg_addr == bitr_pkg::SYSCTL_ADDR // [R9]
      |=> reg_rdata == {6'h00, $past(crystal_option), $past(system_clock_mode)})
      else $error("system control read wrong");

   a_vector_fixed: assert property (irq_vector == bitr_pkg::VECTOR_ADDR) // [R5]
      else $error("interrupt vector changed");

endmodule
`default_nettype wire

// ===== src/bitr_pkg.sv
// Shared constants and types of the basic interval timer
package bitr_pkg;

   // Register byte addresses on the register port
   localparam logic [7:0] MODE_ADDR   = 8'hd8;
   localparam logic [7:0] COUNT_ADDR  = 8'hd9;
   localparam logic [7:0] STATUS_ADDR = 8'hda;
   localparam logic [7:0] MASK_ADDR   = 8'hdb;
   localparam logic [7:0] SYSCTL_ADDR = 8'hdc;

   // Field positions in the mode register
   localparam int RUN_BIT = 7;
   localparam int PSC_HI  = 6;
   localparam int PSC_LO  = 4;
   localparam int RTC_BIT = 0;

   // Field positions in status, mask and system control
   localparam int OVF_BIT   = 0;
   localparam int SYSTEM_CLOCK_MODE_BIT = 0;
   localparam int OPT_BIT   = 1;

   // Reset values and counter limits
   localparam logic [7:0] MODE_RESET  = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] CNT_MAX     = 8'hff;
   localparam logic [7:0] CNT_ONE     = 8'h01;
   localparam logic [7:0] VECTOR_ADDR = 8'h08;

   // Prescaler layout
   localparam int         DIV_WIDTH = 7;
   localparam logic [6:0] DIV_MAX   = 7'h7f;
   localparam logic [6:0] RTC_MASK  = 7'h3f;

   // Clock source of the counter
   typedef enum logic [2:0] {
      SRC_HOSC = 3'b001,
      SRC_LOSC = 3'b010,
      SRC_RTC  = 3'b100
   } bitr_src_type;

endpackage

// ===== src/bitr_tick_if.sv
// Control and tick signals between timer core and prescaler
`timescale 1ns/1ps
`default_nettype none
interface bitr_tick_if;
   logic                  run;
   logic [2:0]            psc_sel;
   bitr_pkg::bitr_src_type src;
   logic                  tick;

   modport ctl (output run, output psc_sel, output src, input tick);
   modport psc (input run, input psc_sel, input src, output tick);
endinterface
`default_nettype wire

// ===== src/bitr_prescaler.sv
// Oscillator synchronisers and divide-by-2^n prescaler
`timescale 1ns/1ps
`default_nettype none
module bitr_prescaler (
   // Clock and reset
   input  wire logic  core_clk,
   input  wire logic  nrst,
   // Raw oscillator inputs
   input  wire logic  hosc_in,
   input  wire logic  losc_in,
   input  wire logic  xtal_in,
   // Link to timer core
   bitr_tick_if.psc   tif
);

   logic [2:0]                      raw;
   logic [2:0]                      sync1;
   logic [2:0]                      sync2;
   logic [2:0]                      sync3;
   logic [2:0]                      level;
   logic [2:0]                      rise;
   logic                            src_tick;
   logic [bitr_pkg::DIV_WIDTH-1:0]  div;
   logic [bitr_pkg::DIV_WIDTH-1:0]  mask;

   assign raw = {xtal_in, losc_in, hosc_in};

   // Three-stage synchroniser; level moves only when stages 2 and 3 agree
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         sync3 <= 3'h0;
         level <= 3'h0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         sync3 <= sync2;
         level <= ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & level);
      end
   end

   assign rise = (sync2 ~^ sync3) & sync3 & ~level;

   // Source pick and division mask; select field ignored in crystal mode
   always_comb begin
      src_tick = 1'b0;
      mask     = bitr_pkg::DIV_MAX >> tif.psc_sel; // [R8]
      case (tif.src)
         bitr_pkg::SRC_HOSC: src_tick = rise[0]; // [R9]
         bitr_pkg::SRC_LOSC: src_tick = rise[1]; // [R9]
         bitr_pkg::SRC_RTC: begin
            src_tick = rise[2]; // [R10]
            mask     = bitr_pkg::RTC_MASK; // [R11] [R13]
         end
         default: src_tick = 1'b0;
      endcase
   end

   // Divider restarts while the timer is stopped
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         div <= '0;
      end else if (!tif.run) begin
         div <= '0;
      end else if (src_tick) begin
         div <= div + 7'h01;
      end
   end

   assign tif.tick = tif.run & src_tick & ((div & mask) == mask); // [R8]

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_rtc_div_64: assert property (tif.tick && tif.src == bitr_pkg::SRC_RTC // [R11]
      |-> div[5:0] == 6'h3f && rise[2]) else $error("crystal tick not at 64");
   a_fast_div_1: assert property (tif.run && src_tick && tif.psc_sel == 3'h7 // [R8]
      && tif.src != bitr_pkg::SRC_RTC |-> tif.tick) else $error("divide by one lost");
endmodule
`default_nettype wire

// ===== verification/tb.sv
// Self-checking testbench of the basic interval timer
`timescale 1ns/1ps
`default_nettype none
module tb;
   // Clock, reset and stimulus
   logic       core_clk;
   logic       nrst;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;
   logic       reg_wr;
   logic       reg_rd;
   logic [7:0] reg_rdata;
   logic       hosc_in;
   logic       losc_in;
   logic       xtal_in;
   logic       option_strap;
   logic       green_mode;
   logic       irq;
   logic [7:0] irq_vector;
   logic       wake_req;
   logic       wake_seen;
   int         n_mismatch;
   int         n_compared;

   // Design under test
   bitr_timer uut (
      .core_clk     (core_clk),
      .nrst         (nrst),
      .reg_addr     (reg_addr),
      .reg_wdata    (reg_wdata),
      .reg_wr       (reg_wr),
      .reg_rd       (reg_rd),
      .reg_rdata    (reg_rdata),
      .hosc_in      (hosc_in),
      .losc_in      (losc_in),
      .xtal_in      (xtal_in),
      .option_strap (option_strap),
      .green_mode   (green_mode),
      .irq          (irq),
      .irq_vector   (irq_vector),
      .wake_req     (wake_req)
   );

   // 125 MHz clock
   always #4 core_clk = ~core_clk;

   // Remember any wake pulse
   always @(posedge core_clk) begin
      if (wake_req === 1'b1) begin
         wake_seen <= 1'b1;
      end
   end

   // Compare and count
   task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   // One-cycle register read, data checked in the following cycle
   task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(name, reg_rdata, exp);
   endtask

   // Full oscillator periods on one pin: 0 high, 1 low, 2 crystal
   task automatic pulse(input int which, input int n);
      repeat (n) begin
         @(posedge core_clk);
         case (which)
            0: hosc_in <= 1'b1;
            1: losc_in <= 1'b1;
            default: xtal_in <= 1'b1;
         endcase
         repeat (4) @(posedge core_clk);
         hosc_in <= 1'b0;
         losc_in <= 1'b0;
         xtal_in <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
   endtask

   // Apply reset for 12 cycles
   task automatic do_reset();
      @(posedge core_clk);
      nrst <= 1'b0;
      repeat (12) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge core_clk);
   endtask

   // Counts and verdict
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (60000) @(posedge core_clk);
      n_mismatch++;
      close_out();
   end

   // Main sequence
   initial begin
      core_clk     = 1'b0;
      nrst         = 1'b0;
      reg_addr     = 8'h00;
      reg_wdata    = 8'h00;
      reg_wr       = 1'b0;
      reg_rd       = 1'b0;
      hosc_in      = 1'b0;
      losc_in      = 1'b0;
      xtal_in      = 1'b0;
      option_strap = 1'b0;
      green_mode   = 1'b0;
      wake_seen    = 1'b0;
      n_mismatch   = 0;
      n_compared   = 0;
      do_reset();
      // Reset values, reserved bits, unmapped place
      rd("mode", bitr_pkg::MODE_ADDR, 8'h00);
      rd("count", bitr_pkg::COUNT_ADDR, 8'h00);
      rd("status", bitr_pkg::STATUS_ADDR, 8'h00);
      rd("sysctl", bitr_pkg::SYSCTL_ADDR, 8'h00);
      wr(bitr_pkg::MODE_ADDR, 8'h7f);
      rd("mode", bitr_pkg::MODE_ADDR, 8'h71);
      wr(8'h40, 8'h55);
      rd("unmapped", 8'h40, 8'h00);
      // Every prescale code: count steps after 2^(7-code) edges
      for (int code = 0; code < 8; code++) begin
         wr(bitr_pkg::MODE_ADDR, 8'h00);
         wr(bitr_pkg::COUNT_ADDR, 8'h00);
         wr(bitr_pkg::MODE_ADDR, {1'b1, 3'(code), 4'h0});
         pulse(0, (1 << (7 - code)) - 1);
         rd("count early", bitr_pkg::COUNT_ADDR, 8'h00);
         pulse(0, 1);
         rd("count step", bitr_pkg::COUNT_ADDR, 8'h01);
      end
      // Write meets a tick in one cycle: write wins, count goes on from it
      @(posedge core_clk);
      hosc_in <= 1'b1;
      repeat (2) @(posedge core_clk);
      wr(bitr_pkg::COUNT_ADDR, 8'h80);
      hosc_in <= 1'b0;
      rd("count write", bitr_pkg::COUNT_ADDR, 8'h80);
      pulse(0, 1);
      rd("count", bitr_pkg::COUNT_ADDR, 8'h81);
      // Hold while stopped
      wr(bitr_pkg::MODE_ADDR, 8'h70);
      pulse(0, 3);
      rd("count held", bitr_pkg::COUNT_ADDR, 8'h81);
      // Overflow, sticky flag, interrupt and vector
      wr(bitr_pkg::MASK_ADDR, 8'h01);
      rd("mask", bitr_pkg::MASK_ADDR, 8'h01);
      wr(bitr_pkg::COUNT_ADDR, 8'hfe);
      wr(bitr_pkg::MODE_ADDR, 8'hf0);
      pulse(0, 1);
      rd("status", bitr_pkg::STATUS_ADDR, 8'h00);
      chk("irq", {7'h00, irq}, 8'h00);
      pulse(0, 1);
      rd("count wrap", bitr_pkg::COUNT_ADDR, 8'h00);
      rd("status", bitr_pkg::STATUS_ADDR, 8'h01);
      chk("irq", {7'h00, irq}, 8'h01);
      chk("vector", irq_vector, 8'h08);
      chk("wake", {7'h00, wake_seen}, 8'h00);
      pulse(0, 1);
      rd("count after", bitr_pkg::COUNT_ADDR, 8'h01);
      wr(bitr_pkg::MASK_ADDR, 8'h00);
      #1;
      chk("irq masked", {7'h00, irq}, 8'h00);
      wr(bitr_pkg::STATUS_ADDR, 8'h00);
      rd("status kept", bitr_pkg::STATUS_ADDR, 8'h01);
      wr(bitr_pkg::STATUS_ADDR, 8'h01);
      rd("status clear", bitr_pkg::STATUS_ADDR, 8'h00);
      // Green mode overflow wakes
      @(posedge core_clk);
      green_mode <= 1'b1;
      wr(bitr_pkg::MASK_ADDR, 8'h01);
      wr(bitr_pkg::COUNT_ADDR, 8'hff);
      pulse(0, 1);
      chk("wake", {7'h00, wake_seen}, 8'h01);
      rd("status green", bitr_pkg::STATUS_ADDR, 8'h01);
      @(posedge core_clk);
      green_mode <= 1'b0;
      wr(bitr_pkg::STATUS_ADDR, 8'h01);
      #1;
      chk("irq cleared", {7'h00, irq}, 8'h00);
      // Low oscillator path
      wr(bitr_pkg::MODE_ADDR, 8'h70);
      wr(bitr_pkg::COUNT_ADDR, 8'h00);
      wr(bitr_pkg::SYSCTL_ADDR, 8'h01);
      rd("sysctl", bitr_pkg::SYSCTL_ADDR, 8'h01);
      wr(bitr_pkg::MODE_ADDR, 8'hf0);
      pulse(0, 2);
      rd("count losc", bitr_pkg::COUNT_ADDR, 8'h00);
      pulse(1, 1);
      rd("count losc", bitr_pkg::COUNT_ADDR, 8'h01);
      wr(bitr_pkg::SYSCTL_ADDR, 8'h00);
      // Crystal select without option strap stays on oscillator
      wr(bitr_pkg::MODE_ADDR, 8'h71);
      wr(bitr_pkg::COUNT_ADDR, 8'h00);
      wr(bitr_pkg::MODE_ADDR, 8'hf1);
      pulse(2, 2);
      pulse(0, 1);
      rd("count no strap", bitr_pkg::COUNT_ADDR, 8'h01);
      // Crystal mode with strap: fixed divide by 64, select ignored
      @(posedge core_clk);
      option_strap <= 1'b1;
      do_reset();
      rd("sysctl", bitr_pkg::SYSCTL_ADDR, 8'h02);
      wr(bitr_pkg::MODE_ADDR, 8'h71);
      wr(bitr_pkg::MODE_ADDR, 8'hf1);
      rd("mode rtc", bitr_pkg::MODE_ADDR, 8'hf1);
      pulse(0, 2);
      pulse(2, 63);
      rd("count rtc", bitr_pkg::COUNT_ADDR, 8'h00);
      pulse(2, 1);
      rd("count rtc", bitr_pkg::COUNT_ADDR, 8'h01);
      close_out();
   end
endmodule
`default_nettype wire
